// *** rtl/safety_alarm.sv ***
// Alarm logic for safety request inputs and motion monitoring
//
// Overview of operation
// - Pair A channel off without partner off in 10 s raises pair-A alarm.
// - Pair A channel on without partner on in 10 s raises pair-A alarm.
// - Pair B channel off without partner off in 10 s raises pair-B alarm.
// - Pair B channel on without partner on in 10 s raises pair-B alarm.
// - Current request channel states are readable as an input-state monitor.
// - Function A decelerating modes: speed above A limit raises function-A alarm.
// - Function A position monitoring: distance above A limit raises function-A alarm.
// - Function B decelerating modes: speed above B limit raises function-B alarm.
// - Function B position monitoring: distance above B limit raises function-B alarm.
// - Motor position data error raises feedback-data alarm.
//
// The placing of the registers and strobed register access were left to the implementer.
`default_nettype none
module safety_alarm #(
	parameter longint unsigned DISCREPANCY_LIMIT = safety_alarm_pkg::DISCREPANCY_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_request_a_channel_one,
	input wire logic i_request_a_channel_two,
	input wire logic i_request_b_channel_one,
	input wire logic i_request_b_channel_two,
	input wire safety_alarm_pkg::motor_fb_s i_motor_fb,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic [safety_alarm_pkg::ALARM_W-1:0] o_alarm,
	output logic o_irq
);
	localparam int AW = safety_alarm_pkg::ALARM_W;
	// Bit positions of the request channels in the synchronised vector
	localparam int SYNC_A_ONE = 0;
	localparam int SYNC_A_TWO = 1;
	localparam int SYNC_B_ONE = 2;
	localparam int SYNC_B_TWO = 3;

	// ==========================================================
	// Input synchronisers
	// ==========================================================
	logic [3:0] req_meta_reg;
	logic [3:0] req_sync_reg;

	// Two stages on the asynchronous request pins
	// Only the second stage is read; the first may still be settling
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			req_meta_reg <= 4'h0;
			req_sync_reg <= 4'h0;
		end else begin
			req_meta_reg <= {i_request_b_channel_two, i_request_b_channel_one,
				i_request_a_channel_two, i_request_a_channel_one};
			req_sync_reg <= req_meta_reg;
		end
	end

	// ==========================================================
	// Pair discrepancy timers
	// ==========================================================
	logic pair_a_timeout;
	logic pair_b_timeout;

	// One timer per pair covers both on and off directions
	// The timers saturate, so a long fault can neither wrap nor clear itself
	pair_discrepancy #(.LIMIT_CYCLES(DISCREPANCY_LIMIT)) u_pair_a (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_chan_one(req_sync_reg[SYNC_A_ONE]),
		.i_chan_two(req_sync_reg[SYNC_A_TWO]),
		.o_timeout(pair_a_timeout)
	);

	pair_discrepancy #(.LIMIT_CYCLES(DISCREPANCY_LIMIT)) u_pair_b (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_chan_one(req_sync_reg[SYNC_B_ONE]),
		.i_chan_two(req_sync_reg[SYNC_B_TWO]),
		.o_timeout(pair_b_timeout)
	);

	// ==========================================================
	// Configuration registers
	// ==========================================================
	safety_alarm_pkg::func_limits_s limits_a_reg;
	safety_alarm_pkg::func_limits_s limits_b_reg;
	logic [AW-1:0] mask_reg;

	// Software writes of function selection and limits
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			limits_a_reg <= '0;
			limits_b_reg <= '0;
		end else if (i_wr) begin
			unique case (i_addr)
				safety_alarm_pkg::ADDR_FUNC_SEL: begin
					limits_a_reg.func <= safety_alarm_pkg::safety_func_e'(
						i_wdata[safety_alarm_pkg::FSEL_A_LSB +: 2]);
					limits_b_reg.func <= safety_alarm_pkg::safety_func_e'(
						i_wdata[safety_alarm_pkg::FSEL_B_LSB +: 2]);
				end
				safety_alarm_pkg::ADDR_SPEED_A: begin
					limits_a_reg.speed_limit <= i_wdata[safety_alarm_pkg::SPEED_W-1:0];
				end
				safety_alarm_pkg::ADDR_DIST_A: begin
					limits_a_reg.dist_limit <= i_wdata;
				end
				safety_alarm_pkg::ADDR_SPEED_B: begin
					limits_b_reg.speed_limit <= i_wdata[safety_alarm_pkg::SPEED_W-1:0];
				end
				safety_alarm_pkg::ADDR_DIST_B: begin
					limits_b_reg.dist_limit <= i_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// Interrupt mask; all unmasked after reset
	// The mask gates only the interrupt; alarms latch whatever it holds
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			mask_reg <= safety_alarm_pkg::MASK_RESET;
		end else if (i_wr && i_addr == safety_alarm_pkg::ADDR_MASK) begin
			mask_reg <= i_wdata[AW-1:0];
		end
	end

	// ==========================================================
	// Motion monitoring
	// ==========================================================
	// Speed is watched in every decelerating mode
	function automatic logic speed_watched(input safety_alarm_pkg::safety_func_e f);
		return f == safety_alarm_pkg::decelerating_base_block ||
			f == safety_alarm_pkg::decelerating_position_monitoring ||
			f == safety_alarm_pkg::decelerating_limited_speed;
	endfunction

	// Over-limit check for one safety function
	// Compares are strict, so a sample exactly at its limit is still legal
	function automatic logic func_violation(input safety_alarm_pkg::func_limits_s lim,
		input safety_alarm_pkg::motor_fb_s fb);
		logic over_speed;
		logic over_dist;
		over_speed = speed_watched(lim.func) && (fb.speed > lim.speed_limit);
		over_dist = (lim.func == safety_alarm_pkg::decelerating_position_monitoring) &&
			(fb.distance > lim.dist_limit);
		return over_speed || over_dist;
	endfunction

	logic func_a_viol;
	logic func_b_viol;
	assign func_a_viol = func_violation(limits_a_reg, i_motor_fb);
	assign func_b_viol = func_violation(limits_b_reg, i_motor_fb);

	// ==========================================================
	// Alarm latches and interrupt status
	// ==========================================================
	logic [AW-1:0] event_vec;
	logic [AW-1:0] latched_reg;
	logic [AW-1:0] status_reg;

	// Collect the alarm sources in bit order
	// Feedback is on this clock already, so it needs no synchroniser
	always_comb begin
		event_vec = '0;
		event_vec[safety_alarm_pkg::BIT_FEEDBACK] = i_motor_fb.pos_error;
		event_vec[safety_alarm_pkg::BIT_PAIR_A] = pair_a_timeout;
		event_vec[safety_alarm_pkg::BIT_PAIR_B] = pair_b_timeout;
		event_vec[safety_alarm_pkg::BIT_FUNC_A] = func_a_viol;
		event_vec[safety_alarm_pkg::BIT_FUNC_B] = func_b_viol;
	end

	// Alarms stay latched until restart; software cannot clear them
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			latched_reg <= '0;
		end else begin
			latched_reg <= latched_reg | event_vec;
		end
	end

	// Sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			status_reg <= '0;
		end else if (i_wr && i_addr == safety_alarm_pkg::ADDR_STATUS) begin
			status_reg <= (status_reg & ~i_wdata[AW-1:0]) | event_vec;
		end else begin
			status_reg <= status_reg | event_vec;
		end
	end

	assign o_alarm = latched_reg;
	assign o_irq = |(status_reg & mask_reg);

	// ==========================================================
	// Register read port
	// ==========================================================
	// Read data valid one cycle after the strobe, zero otherwise
	// A zero idle value keeps a stale word from being taken as an answer
	always_ff @(posedge i_ref_clk) begin
		if (i_reset || !i_rd) begin
			o_rdata <= 32'h0000_0000;
		end else begin
			unique case (i_addr)
				safety_alarm_pkg::ADDR_STATUS: o_rdata <= 32'(status_reg);
				safety_alarm_pkg::ADDR_MASK: o_rdata <= 32'(mask_reg);
				safety_alarm_pkg::ADDR_INPUT_STATE: o_rdata <= 32'(req_sync_reg);
				safety_alarm_pkg::ADDR_FUNC_SEL: begin
					o_rdata <= 32'(limits_a_reg.func) |
						(32'(limits_b_reg.func) << safety_alarm_pkg::FSEL_B_LSB);
				end
				safety_alarm_pkg::ADDR_SPEED_A: o_rdata <= 32'(limits_a_reg.speed_limit);
				safety_alarm_pkg::ADDR_DIST_A: o_rdata <= limits_a_reg.dist_limit;
				safety_alarm_pkg::ADDR_SPEED_B: o_rdata <= 32'(limits_b_reg.speed_limit);
				safety_alarm_pkg::ADDR_DIST_B: o_rdata <= limits_b_reg.dist_limit;
				safety_alarm_pkg::ADDR_LATCHED: o_rdata <= 32'(latched_reg);
				default: o_rdata <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Assertion helpers
	// ==========================================================
	// Disagreement counts kept apart from the timers, so a slip in either shows up.
	// They saturate at the window like the timers and are read by assertions only.
	longint unsigned gap_a_reg;
	longint unsigned gap_b_reg;

	// Cycles that pair A has disagreed without a break
	always_ff @(posedge i_ref_clk) begin
		if (i_reset || (req_sync_reg[SYNC_A_ONE] == req_sync_reg[SYNC_A_TWO])) begin
			gap_a_reg <= 64'h0000_0000_0000_0000;
		end else if (gap_a_reg != DISCREPANCY_LIMIT) begin
			gap_a_reg <= gap_a_reg + 64'h0000_0000_0000_0001;
		end
	end

	// Cycles that pair B has disagreed without a break
	always_ff @(posedge i_ref_clk) begin
		if (i_reset || (req_sync_reg[SYNC_B_ONE] == req_sync_reg[SYNC_B_TWO])) begin
			gap_b_reg <= 64'h0000_0000_0000_0000;
		end else if (gap_b_reg != DISCREPANCY_LIMIT) begin
			gap_b_reg <= gap_b_reg + 64'h0000_0000_0000_0001;
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	// Pair timers, input monitor and request synchroniser
	a_pair_a_alarm: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		pair_a_timeout |=> latched_reg[safety_alarm_pkg::BIT_PAIR_A])
		else $error("pair A timeout not latched");
	a_pair_a_agree: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(req_sync_reg[SYNC_A_ONE] == req_sync_reg[SYNC_A_TWO]) |=> !pair_a_timeout)
		else $error("pair A timeout while channels agree");
	a_pair_a_window: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		pair_a_timeout == (gap_a_reg == DISCREPANCY_LIMIT))
		else $error("pair A window length wrong");
	a_pair_a_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(pair_a_timeout && req_sync_reg[SYNC_A_ONE] != req_sync_reg[SYNC_A_TWO])
		|=> pair_a_timeout)
		else $error("pair A timeout dropped while channels disagree");
	a_pair_b_alarm: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		pair_b_timeout |=> latched_reg[safety_alarm_pkg::BIT_PAIR_B])
		else $error("pair B timeout not latched");
	a_pair_b_agree: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(req_sync_reg[SYNC_B_ONE] == req_sync_reg[SYNC_B_TWO]) |=> !pair_b_timeout)
		else $error("pair B timeout while channels agree");
	a_pair_b_window: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		pair_b_timeout == (gap_b_reg == DISCREPANCY_LIMIT))
		else $error("pair B window length wrong");
	a_pair_b_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(pair_b_timeout && req_sync_reg[SYNC_B_ONE] != req_sync_reg[SYNC_B_TWO])
		|=> pair_b_timeout)
		else $error("pair B timeout dropped while channels disagree");
	a_input_monitor: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(i_rd && i_addr == safety_alarm_pkg::ADDR_INPUT_STATE) |=>
		o_rdata[3:0] == $past(req_sync_reg))
		else $error("input monitor read wrong");
	a_sync_stage: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		!$past(i_reset) |-> (req_sync_reg == $past(req_meta_reg)))
		else $error("request synchroniser skipped a stage");

	// Motion monitoring and feedback
	a_func_a_speed: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(speed_watched(limits_a_reg.func) && i_motor_fb.speed > limits_a_reg.speed_limit)
		|=> latched_reg[safety_alarm_pkg::BIT_FUNC_A])
		else $error("function A speed alarm missed");
	a_func_a_dist: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(limits_a_reg.func == safety_alarm_pkg::decelerating_position_monitoring &&
		i_motor_fb.distance > limits_a_reg.dist_limit)
		|=> latched_reg[safety_alarm_pkg::BIT_FUNC_A])
		else $error("function A distance alarm missed");
	a_func_b_speed: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(speed_watched(limits_b_reg.func) && i_motor_fb.speed > limits_b_reg.speed_limit)
		|=> latched_reg[safety_alarm_pkg::BIT_FUNC_B])
		else $error("function B speed alarm missed");
	a_func_b_dist: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(limits_b_reg.func == safety_alarm_pkg::decelerating_position_monitoring &&
		i_motor_fb.distance > limits_b_reg.dist_limit)
		|=> latched_reg[safety_alarm_pkg::BIT_FUNC_B])
		else $error("function B distance alarm missed");
	a_func_a_quiet: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(limits_a_reg.func == safety_alarm_pkg::FUNC_NONE) |-> !func_a_viol)
		else $error("function A alarm without a monitoring mode");
	a_func_b_quiet: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(limits_b_reg.func == safety_alarm_pkg::FUNC_NONE) |-> !func_b_viol)
		else $error("function B alarm without a monitoring mode");
	a_feedback_err: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_motor_fb.pos_error |=> o_alarm[safety_alarm_pkg::BIT_FEEDBACK] ##1
		o_alarm[safety_alarm_pkg::BIT_FEEDBACK])
		else $error("feedback alarm not raised");

	// Latches, status, interrupt and read port
	a_alarm_sticky: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		$past(i_reset) || (latched_reg == ($past(latched_reg) | $past(event_vec))))
		else $error("latched alarm dropped");
	a_status_set: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(event_vec != '0) |=> ((status_reg & $past(event_vec)) == $past(event_vec)))
		else $error("status event lost");
	a_irq_level: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		((event_vec & mask_reg) != '0 && !i_wr) |=> o_irq)
		else $error("irq not raised by unmasked event");
	a_mask_irq: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(mask_reg == '0) |-> !o_irq)
		else $error("irq raised while fully masked");
	a_rdata_idle: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		!i_rd |=> (o_rdata == 32'h0000_0000))
		else $error("read data outside the answer cycle");
	a_status_read: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(i_rd && i_addr == safety_alarm_pkg::ADDR_STATUS) |=>
		(o_rdata[AW-1:0] == $past(status_reg)))
		else $error("status read wrong");
	a_latched_read: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(i_rd && i_addr == safety_alarm_pkg::ADDR_LATCHED) |=>
		(o_rdata[AW-1:0] == $past(latched_reg)))
		else $error("latched alarm read wrong");
	a_mask_read: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(i_rd && i_addr == safety_alarm_pkg::ADDR_MASK) |=>
		(o_rdata[AW-1:0] == $past(mask_reg)))
		else $error("mask read wrong");
endmodule
`default_nettype wire

// *** rtl/safety_alarm_pkg.sv ***
// Constants and carrier types for the safety request and motion monitor alarms
`default_nettype none
package safety_alarm_pkg;
	// Clock and discrepancy timing
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned DISCREPANCY_SEC = 10;
	localparam longint unsigned DISCREPANCY_CYCLES = longint'(DISCREPANCY_SEC) * longint'(CLK_HZ);
	localparam int TIMER_W = 32;
	// Widths of motion data and parameters
	localparam int SPEED_W = 16;
	localparam int DIST_W = 32;
	// Register index map, word addressed by byte address
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_MASK = 8'h04;
	localparam logic [7:0] ADDR_INPUT_STATE = 8'h08;
	localparam logic [7:0] ADDR_FUNC_SEL = 8'h0C;
	localparam logic [7:0] ADDR_SPEED_A = 8'h10;
	localparam logic [7:0] ADDR_DIST_A = 8'h14;
	localparam logic [7:0] ADDR_SPEED_B = 8'h18;
	localparam logic [7:0] ADDR_DIST_B = 8'h1C;
	localparam logic [7:0] ADDR_LATCHED = 8'h20;
	// Alarm bit positions in status, mask and latched registers
	localparam int BIT_FEEDBACK = 0;
	localparam int BIT_PAIR_A = 1;
	localparam int BIT_PAIR_B = 2;
	localparam int BIT_FUNC_A = 3;
	localparam int BIT_FUNC_B = 4;
	localparam int ALARM_W = 5;
	// Function select field positions
	localparam int FSEL_A_LSB = 0;
	localparam int FSEL_B_LSB = 4;
	localparam int FSEL_W = 4;
	// Reset values
	localparam logic [ALARM_W-1:0] MASK_RESET = 5'h1F;
	localparam logic [31:0] FUNC_SEL_RESET = 32'h0000_0000;

	// Safety function kinds
	typedef enum logic [1:0] {
		FUNC_NONE,
		decelerating_base_block,
		decelerating_position_monitoring,
		decelerating_limited_speed
	} safety_func_e;

	// Monitoring limits of one safety function
	typedef struct packed {
		safety_func_e func;
		logic [SPEED_W-1:0] speed_limit;
		logic [DIST_W-1:0] dist_limit;
	} func_limits_s;

	// Motor feedback sample
	typedef struct packed {
		logic [SPEED_W-1:0] speed;
		logic [DIST_W-1:0] distance;
		logic pos_error;
	} motor_fb_s;
endpackage
`default_nettype wire

// *** rtl/pair_discrepancy.sv ***
// Discrepancy timer for one dual-channel safety request pair
`default_nettype none
module pair_discrepancy #(
	parameter longint unsigned LIMIT_CYCLES = safety_alarm_pkg::DISCREPANCY_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_chan_one,
	input wire logic i_chan_two,
	output logic o_timeout
);
	localparam int W = safety_alarm_pkg::TIMER_W + 8;
	localparam logic [W-1:0] LIMIT = W'(LIMIT_CYCLES);
	logic [W-1:0] count_reg;

	// Count while channels disagree; agreement restarts the window
	always_ff @(posedge i_ref_clk) begin
		if (i_reset || (i_chan_one == i_chan_two)) begin
			count_reg <= '0;
		end else if (count_reg != LIMIT) begin
			count_reg <= count_reg + W'(1);
		end
	end

	// Timeout when the disagreement reaches the full window
	assign o_timeout = (count_reg == LIMIT);
endmodule
`default_nettype wire

// *** test/request_source.sv ***
// Model of the external safety equipment driving both request pairs
`default_nettype none
module request_source (
	input wire logic i_ref_clk,
	output logic [3:0] o_chan
);
	timeunit 1ns;
	timeprecision 1ns;
	// Bit order: pair A one, A two, pair B one, B two; all requests off at power-up
	initial o_chan = 4'h0;
	// Second channel lags the first by skew cycles; a large skew is a wiring fault
	task automatic switch_pair(input int pair, input logic level, input int skew);
		@(posedge i_ref_clk);
		o_chan[2*pair] <= level;
		repeat (skew) @(posedge i_ref_clk);
		o_chan[2*pair+1] <= level;
	endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the safety request and motion monitor alarms
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	// Short discrepancy window keeps the run brief
	localparam longint unsigned LIM = 20;
	logic i_ref_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [3:0] chan;
	safety_alarm_pkg::motor_fb_s fb = '0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata;
	logic [safety_alarm_pkg::ALARM_W-1:0] o_alarm;
	logic o_irq;
	logic [31:0] exp_v;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;

	request_source request_source_i (.i_ref_clk(i_ref_clk), .o_chan(chan));
	safety_alarm #(.DISCREPANCY_LIMIT(LIM)) safety_alarm_i (
		.i_ref_clk(i_ref_clk), .i_reset(i_reset),
		.i_request_a_channel_one(chan[0]), .i_request_a_channel_two(chan[1]),
		.i_request_b_channel_one(chan[2]), .i_request_b_channel_two(chan[3]),
		.i_motor_fb(fb), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_alarm(o_alarm), .o_irq(o_irq));

	// ==========================================
	// Clock and hang guard
	initial forever #5 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end

	// ==========================================
	// Shared tasks; each starts and ends just after a clock edge
	task automatic final_report();
		$display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	// Strobe drops at the edge, so a following access never hits the same time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		check(nm, o_rdata, exp);
	endtask
	task automatic restart();
		i_reset <= 1'b1;
		tick(3);
		i_reset <= 1'b0;
		tick(1);
	endtask

	// ==========================================
	// Main sequence
	initial begin
		repeat (20) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		tick(1);
		rd(safety_alarm_pkg::ADDR_MASK, 32'h0000_001F, "mask reset");
		rd(8'hFC, 32'h0000_0000, "unmapped");
		// Skew inside the window, twice in a row: the timer must restart each time
		for (int p = 0; p < 2; p++) begin
			request_source_i.switch_pair(p, 1'b1, 15);
			tick(30);
			rd(safety_alarm_pkg::ADDR_INPUT_STATE, (p == 0) ? 32'h0000_0003 : 32'h0000_000C,
				"inputs");
			request_source_i.switch_pair(p, 1'b0, 15);
			tick(30);
			check("no pair alarm", 32'(o_alarm), 32'h0);
		end
		// Partner lagging beyond the window, each pair, both directions
		for (int p = 0; p < 2; p++) begin
			for (int lv = 0; lv < 2; lv++) begin
				restart();
				if (lv == 0)
					request_source_i.switch_pair(p, 1'b1, 0);
				tick(5);
				request_source_i.switch_pair(p, lv[0], 30);
				tick(3);
				exp_v = 32'h1 << (safety_alarm_pkg::BIT_PAIR_A + p);
				check("pair alarm", 32'(o_alarm), exp_v);
			end
		end
		// Interrupt: raised, masked, cleared; the alarm itself stays latched
		check("irq up", 32'(o_irq), 32'h1);
		rd(safety_alarm_pkg::ADDR_STATUS, 32'h0000_0004, "status");
		wr(safety_alarm_pkg::ADDR_MASK, 32'h0000_0000);
		check("irq masked", 32'(o_irq), 32'h0);
		wr(safety_alarm_pkg::ADDR_MASK, 32'h0000_001F);
		wr(safety_alarm_pkg::ADDR_STATUS, 32'h0000_0004);
		check("irq cleared", 32'(o_irq), 32'h0);
		rd(safety_alarm_pkg::ADDR_LATCHED, 32'h0000_0004, "latched");
		// Every mode of both functions, speed then distance, at and past the limit
		for (int f = 0; f < 2; f++) begin
			for (int m = 0; m < 4; m++) begin
				for (int d = 0; d < 2; d++) begin
					fb <= '0;
					restart();
					exp_v = 32'(m) << (safety_alarm_pkg::FSEL_B_LSB * f);
					wr(safety_alarm_pkg::ADDR_FUNC_SEL, exp_v);
					wr(8'(safety_alarm_pkg::ADDR_SPEED_A + 8 * f), 32'h0000_0064);
					wr(8'(safety_alarm_pkg::ADDR_DIST_A + 8 * f), 32'h0000_03E8);
					rd(safety_alarm_pkg::ADDR_FUNC_SEL, exp_v, "func select");
					rd(8'(safety_alarm_pkg::ADDR_SPEED_A + 8 * f), 32'h0000_0064, "speed");
					if (d == 1)
						fb <= '{16'h0000, 32'h0000_03E8, 1'b0};
					else
						fb <= '{16'h0064, 32'h0000_0000, 1'b0};
					tick(4);
					check("at limit", 32'(o_alarm), 32'h0);
					if (d == 1)
						fb <= '{16'h0000, 32'h0000_03E9, 1'b0};
					else
						fb <= '{16'h0065, 32'h0000_0000, 1'b0};
					tick(4);
					exp_v = 32'h0;
					if ((d == 0 && m != 0) || (d == 1 && m == 2))
						exp_v = 32'h1 << (safety_alarm_pkg::BIT_FUNC_A + f);
					check("motion alarm", 32'(o_alarm), exp_v);
				end
			end
		end
		// A single bad position sample must latch
		fb <= '0;
		restart();
		fb <= '{16'h0000, 32'h0000_0000, 1'b1};
		tick(1);
		fb <= '0;
		tick(6);
		check("feedback", 32'(o_alarm), 32'h1 << safety_alarm_pkg::BIT_FEEDBACK);
		final_report();
	end
endmodule
`default_nettype wire
